// >>> hdl/sfp_regs.sv
`timescale 1ns/1ns
module sfp_regs
   import sfp_pkg::*;
(
   input  wire logic       clk_sys,
   input  wire logic       rst_n,
   input  wire logic [7:0] mem_addr,
   input  wire logic       mem_wr,
   input  wire sfp_op_t    mem_op,
   input  wire logic [2:0] mem_bit,
   input  wire logic [7:0] mem_wdata,
   output logic [7:0]      mem_rdata,
   input  wire logic       alu_flag_we,
   input  wire logic [3:0] alu_flag_mask,
   input  wire logic [3:0] alu_flags,
   input  wire logic       wdt_timeout,
   input  wire logic       clear_watchdog_instr_exec,
   input  wire logic       halt_exec,
   input  wire logic       sleeping,
   output logic            wake_req,
   input  wire logic [7:0] pin_in,
   output logic [7:0]      pin_out,
   output logic [7:0]      pin_oe,
   output logic [7:0]      pullup_en,
   input  wire logic       bz_wave,
   output logic [1:0]      bz_pin_sel
);

   // ****************************************************************
   // Storage
   // ****************************************************************
   // Arithmetic flags are reset here only so simulation has no X; software
   // must not rely on their power-up value.
   logic [3:0] arith;
   logic       to_flag;
   logic       pd_flag;
   logic [7:0] port_data;
   logic [7:0] port_dir;
   logic [7:0] pullup_sel;
   logic [7:0] wake_sel;
   logic [1:0] bz_en;
   logic [3:0] next_arith;
   logic       next_to;
   logic       next_pd;
   logic [7:0] next_port_data;
   logic [7:0] next_port_dir;
   logic [7:0] next_pullup_sel;
   logic [7:0] next_wake_sel;
   logic [1:0] next_bz_en;
   logic [7:0] pin_sync;
   logic [7:0] fall_seen;
   logic       bz_true_on;
   logic       bz_comp_on;

   // Applies a byte write or a single-bit set or clear to a register value.
   function automatic logic [7:0] apply_op(input logic [7:0] cur, input logic hit);
      logic [7:0] res;
      res = cur;
      if (hit && mem_wr) begin
         unique case (mem_op)
            SFP_OP_WRITE: res = mem_wdata;
            SFP_OP_SET:   res[mem_bit] = 1'b1;
            SFP_OP_CLR:   res[mem_bit] = 1'b0;
            default:      res = cur;
         endcase
      end
      return res;
   endfunction : apply_op

   // ****************************************************************
   // Next-state logic
   // ****************************************************************
   always_comb begin
      logic [7:0] flag_w;
      logic [7:0] bz_w;
      flag_w = apply_op({2'h0, to_flag, pd_flag, arith}, mem_addr == ADDR_FLAG);
      bz_w   = apply_op({4'h0, bz_en, 2'h0}, mem_addr == ADDR_BUZZER);
      // Only the low four bits take software data.
      next_arith = flag_w[3:0] & FLAG_ARITH_MASK[3:0];
      // ALU update wins over a software write in the same cycle.
      for (int i = 0; i < 4; i++) begin
         if (alu_flag_we && alu_flag_mask[i]) begin
            next_arith[i] = alu_flags[i];
         end
      end
      // Flags are never touched by interrupt entry or calls.
      next_to = to_flag;
      next_pd = pd_flag;
      if (clear_watchdog_instr_exec) begin
         next_to = 1'b0;
         next_pd = 1'b0;
      end else if (halt_exec) begin
         next_to = 1'b0;
         next_pd = 1'b1;
      end
      // A time-out in the same cycle as a clear is not lost.
      if (wdt_timeout) begin
         next_to = 1'b1;
      end
      next_port_data  = apply_op(port_data, mem_addr == ADDR_PORT_DATA);
      next_port_dir   = apply_op(port_dir, mem_addr == ADDR_PORT_DIR);
      next_pullup_sel = apply_op(pullup_sel, mem_addr == ADDR_PULLUP);
      next_wake_sel   = apply_op(wake_sel, mem_addr == ADDR_WAKE);
      next_bz_en      = bz_w[BZ_HI:BZ_LO];
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         arith      <= RST_ARITH;
         to_flag    <= RST_SYSFLAGS[1];
         pd_flag    <= RST_SYSFLAGS[0];
         port_data  <= RST_PORT_DATA;
         port_dir   <= RST_PORT_DIR;
         pullup_sel <= RST_PULLUP;
         wake_sel   <= RST_WAKE;
         bz_en      <= RST_BUZZER;
      end else begin
         arith      <= next_arith;
         to_flag    <= next_to;
         pd_flag    <= next_pd;
         port_data  <= next_port_data;
         port_dir   <= next_port_dir;
         pullup_sel <= next_pullup_sel;
         wake_sel   <= next_wake_sel;
         bz_en      <= next_bz_en;
      end
   end

   // ****************************************************************
   // Buzzer decode
   // ****************************************************************
   always_comb begin
      unique case (bz_en)
         BZ_TRUE: begin
            bz_true_on = 1'b1;
            bz_comp_on = 1'b0;
         end
         BZ_BOTH: begin
            bz_true_on = 1'b1;
            bz_comp_on = 1'b1;
         end
         default: begin
            bz_true_on = 1'b0;
            bz_comp_on = 1'b0;
         end
      endcase
   end

   assign bz_pin_sel = {bz_comp_on, bz_true_on};

   // ****************************************************************
   // Port pins
   // ****************************************************************
   // Buzzer true output shares pin 0, complementary output pin 1.
   for (genvar g = 0; g < 8; g++) begin : g_pin
      logic sel;
      logic wave;
      assign sel  = (g == 0) ? bz_true_on : ((g == 1) ? bz_comp_on : 1'b0);
      assign wave = (g == 1) ? !bz_wave : bz_wave;
      sfp_port_bit u_bit (
         .clk_sys    (clk_sys),
         .rst_n      (rst_n),
         .pin_in     (pin_in[g]),
         .dir_in     (port_dir[g]),
         .data       (port_data[g]),
         .pullup_sel (pullup_sel[g]),
         .wake_sel   (wake_sel[g]),
         .bz_sel     (sel),
         .bz_wave    (wave),
         .pin_out    (pin_out[g]),
         .pin_oe     (pin_oe[g]),
         .pullup_en  (pullup_en[g]),
         .pin_sync   (pin_sync[g]),
         .fall_seen  (fall_seen[g])
      );
   end

   assign wake_req = sleeping && (|fall_seen);

   // ****************************************************************
   // Read path
   // ****************************************************************
   // Input pins read the synchronised pin level, outputs read the latch.
   always_comb begin
      unique case (mem_addr)
         ADDR_FLAG:      mem_rdata = {2'h0, to_flag, pd_flag, arith};
         ADDR_PORT_DATA: mem_rdata = (port_dir & pin_sync) | (~port_dir & port_data);
         ADDR_PORT_DIR:  mem_rdata = port_dir;
         ADDR_PULLUP:    mem_rdata = pullup_sel;
         ADDR_WAKE:      mem_rdata = wake_sel;
         ADDR_BUZZER:    mem_rdata = {4'h0, bz_en, 2'h0} & BUZZER_MASK;
         default:        mem_rdata = 8'h00;
      endcase
   end

   // ****************************************************************
   // Checks
   // ****************************************************************
   chk_write_keeps_sys: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (mem_wr && mem_addr == ADDR_FLAG && !wdt_timeout && !clear_watchdog_instr_exec && !halt_exec)
      |=> ($stable(to_flag) && $stable(pd_flag)))
      else $error("flag write changed system flags");

   chk_to_cause: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (!wdt_timeout && !clear_watchdog_instr_exec && !halt_exec) |=> $stable(to_flag))
      else $error("time-out flag changed without cause");

   chk_pd_cause: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (!clear_watchdog_instr_exec && !halt_exec) |=> $stable(pd_flag))
      else $error("power-down flag changed without cause");

   chk_to_set: assert property (@(posedge clk_sys) disable iff (!rst_n)
      wdt_timeout |=> to_flag)
      else $error("time-out flag not set");

   chk_halt_pd: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (halt_exec && !clear_watchdog_instr_exec) |=> pd_flag)
      else $error("halt did not set power-down flag");

   chk_clear_watchdog_instr: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (clear_watchdog_instr_exec && !wdt_timeout) |=> (!pd_flag && !to_flag))
      else $error("clear-watchdog did not clear flags");

   chk_alu_zero: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (alu_flag_we && alu_flag_mask[FLAG_Z]) |=> arith[FLAG_Z] == $past(alu_flags[FLAG_Z]))
      else $error("zero flag not updated");

   chk_pullup_input: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (pullup_en & ~port_dir) == 8'h00)
      else $error("pull-up on output pin");

   chk_pin_dir: assert property (@(posedge clk_sys) disable iff (!rst_n)
      pin_oe == ~port_dir)
      else $error("pin drive disagrees with direction");

   chk_bz_reserved: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (bz_en == BZ_RESERVED || bz_en == BZ_OFF) |-> (bz_pin_sel == 2'h0 && pin_out[0] == port_data[0]))
      else $error("reserved buzzer code drives buzzer");

   chk_bz_both: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (bz_en == BZ_BOTH) |-> (pin_out[1] == !pin_out[0] || !bz_pin_sel[1]))
      else $error("buzzer outputs not complementary");

   // Pin 0, selected for wake, seen falling while asleep, after both synchroniser stages.
   sequence s_sel_fall;
      sleeping && wake_sel[0] && $fell(pin_sync[0]);
   endsequence

   chk_wake_edge: assert property (@(posedge clk_sys) disable iff (!rst_n)
      s_sel_fall |-> wake_req)
      else $error("falling edge did not wake");

   chk_no_wake_awake: assert property (@(posedge clk_sys) disable iff (!rst_n)
      !sleeping |-> !wake_req)
      else $error("wake request while awake");

   chk_alu_carry: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (alu_flag_we && alu_flag_mask[FLAG_C]) |=> arith[FLAG_C] == $past(alu_flags[FLAG_C]))
      else $error("carry flag not updated");

   chk_alu_half_carry: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (alu_flag_we && alu_flag_mask[FLAG_AC]) |=> arith[FLAG_AC] == $past(alu_flags[FLAG_AC]))
      else $error("half carry flag not updated");

   chk_alu_overflow: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (alu_flag_we && alu_flag_mask[FLAG_OV]) |=> arith[FLAG_OV] == $past(alu_flags[FLAG_OV]))
      else $error("overflow flag not updated");

   chk_halt_clears_to: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (halt_exec && !wdt_timeout) |=> !to_flag)
      else $error("halt did not clear time-out flag");

   chk_flag_top_zero: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (mem_addr == ADDR_FLAG) |-> (mem_rdata[7:6] == 2'h0))
      else $error("unused flag bits read nonzero");

   chk_dir_bit_clr: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (mem_wr && mem_op == SFP_OP_CLR && mem_addr == ADDR_PORT_DIR)
      |=> (port_dir == ($past(port_dir) & ~(8'h01 << $past(mem_bit)))))
      else $error("direction bit clear disturbed other bits");

   chk_data_bit_set: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (mem_wr && mem_op == SFP_OP_SET && mem_addr == ADDR_PORT_DATA)
      |=> (port_data == ($past(port_data) | (8'h01 << $past(mem_bit)))))
      else $error("data bit set disturbed other bits");

endmodule : sfp_regs

// >>> hdl/sfp_pkg.sv
package sfp_pkg;

   // ****************************************************************
   // Data memory addresses
   // ****************************************************************
   localparam logic [7:0] ADDR_FLAG      = 8'h0A;
   localparam logic [7:0] ADDR_PORT_DATA = 8'h10;
   localparam logic [7:0] ADDR_PORT_DIR  = 8'h11;
   localparam logic [7:0] ADDR_PULLUP    = 8'h12;
   localparam logic [7:0] ADDR_WAKE      = 8'h13;
   localparam logic [7:0] ADDR_BUZZER    = 8'h1A;

   // ****************************************************************
   // Field positions
   // ****************************************************************
   localparam int FLAG_C  = 0;
   localparam int FLAG_AC = 1;
   localparam int FLAG_Z  = 2;
   localparam int FLAG_OV = 3;
   localparam int FLAG_PD = 4;
   localparam int FLAG_TO = 5;
   localparam int BZ_LO   = 2;
   localparam int BZ_HI   = 3;

   localparam logic [7:0] FLAG_ARITH_MASK = 8'h0F;
   localparam logic [7:0] BUZZER_MASK     = 8'h0C;

   // ****************************************************************
   // Reset values
   // ****************************************************************
   localparam logic [1:0] RST_SYSFLAGS  = 2'h0;
   localparam logic [3:0] RST_ARITH     = 4'h0;
   localparam logic [7:0] RST_PORT_DIR  = 8'hFF;
   localparam logic [7:0] RST_PORT_DATA = 8'hFF;
   localparam logic [7:0] RST_PULLUP    = 8'h00;
   localparam logic [7:0] RST_WAKE      = 8'h00;
   localparam logic [1:0] RST_BUZZER    = 2'h0;

   // ****************************************************************
   // Buzzer enable codes
   // ****************************************************************
   localparam logic [1:0] BZ_OFF      = 2'h0;
   localparam logic [1:0] BZ_RESERVED = 2'h1;
   localparam logic [1:0] BZ_TRUE     = 2'h2;
   localparam logic [1:0] BZ_BOTH     = 2'h3;

   typedef enum logic [1:0] {
      SFP_OP_WRITE,
      SFP_OP_SET,
      SFP_OP_CLR
   } sfp_op_t;

endpackage : sfp_pkg

// >>> hdl/sfp_port_bit.sv
`timescale 1ns/1ns
// One port A pin: pin drive, pull-up, buzzer muxing and falling-edge wake detection.
module sfp_port_bit
   import sfp_pkg::*;
(
   input  wire logic clk_sys,
   input  wire logic rst_n,
   input  wire logic pin_in,
   input  wire logic dir_in,
   input  wire logic data,
   input  wire logic pullup_sel,
   input  wire logic wake_sel,
   input  wire logic bz_sel,
   input  wire logic bz_wave,
   output logic      pin_out,
   output logic      pin_oe,
   output logic      pullup_en,
   output logic      pin_sync,
   output logic      fall_seen
);

   logic meta;
   logic sync;
   logic prev;
   logic next_meta;
   logic next_sync;
   logic next_prev;

   always_comb begin
      next_meta = pin_in;
      next_sync = meta;
      next_prev = sync;
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         meta <= 1'b1;
         sync <= 1'b1;
         prev <= 1'b1;
      end else begin
         meta <= next_meta;
         sync <= next_sync;
         prev <= next_prev;
      end
   end

   // Buzzer only replaces the data source; direction still gates the pin.
   assign pin_out   = bz_sel ? bz_wave : data;
   assign pin_oe    = !dir_in;
   assign pullup_en = pullup_sel && dir_in;
   assign pin_sync  = sync;
   assign fall_seen = wake_sel && prev && !sync;

endmodule : sfp_port_bit

// >>> testbench/sfp_core_model.sv
`timescale 1ns/1ns
// ********
// Core model: issues data memory accesses and flag events.
// ********
module sfp_core_model
   import sfp_pkg::*;
(
   input  wire logic       clk_sys,
   input  wire logic [7:0] mem_rdata,
   output logic [7:0]      mem_addr,
   output logic            mem_wr,
   output sfp_op_t         mem_op,
   output logic [2:0]      mem_bit,
   output logic [7:0]      mem_wdata,
   output logic            alu_flag_we,
   output logic [3:0]      alu_flag_mask,
   output logic [3:0]      alu_flags,
   output logic            wdt_timeout,
   output logic            clear_watchdog_instr_exec,
   output logic            halt_exec
);
   initial begin
      {mem_addr, mem_wr, mem_bit, mem_wdata} = '0;
      mem_op = SFP_OP_WRITE;
      {alu_flag_we, alu_flag_mask, alu_flags} = '0;
      {wdt_timeout, clear_watchdog_instr_exec, halt_exec} = '0;
   end
   task automatic wr(logic [7:0] a, sfp_op_t op, logic [2:0] b, logic [7:0] d);
      @(negedge clk_sys);
      mem_addr = a;
      mem_op = op;
      mem_bit = b;
      mem_wdata = d;
      mem_wr = 1'b1;
      @(negedge clk_sys);
      mem_wr = 1'b0;
   endtask : wr
   // Read data is combinational, so it is taken at the edge while the address stands.
   task automatic rd(logic [7:0] a, output logic [7:0] d);
      @(negedge clk_sys);
      mem_addr = a;
      @(posedge clk_sys);
      d = mem_rdata;
   endtask : rd
   task automatic ev(logic [2:0] e);
      @(negedge clk_sys);
      {wdt_timeout, clear_watchdog_instr_exec, halt_exec} = e;
      @(negedge clk_sys);
      {wdt_timeout, clear_watchdog_instr_exec, halt_exec} = 3'h0;
   endtask : ev
   task automatic alu(logic [3:0] m, logic [3:0] f);
      @(negedge clk_sys);
      {alu_flag_we, alu_flag_mask, alu_flags} = {1'b1, m, f};
      @(negedge clk_sys);
      alu_flag_we = 1'b0;
   endtask : alu
endmodule : sfp_core_model

// >>> testbench/tb_top.sv
`timescale 1ns/1ns
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin fails++; \
   $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module tb_top
   import sfp_pkg::*;
;
   logic       clk_sys = 1'b0;
   logic       rst_n = 1'b0;
   logic       sleeping = 1'b0;
   logic       bz_wave = 1'b0;
   logic [7:0] ext_val = 8'hFF;
   logic [7:0] mem_addr, mem_wdata, mem_rdata, pin_in, pin_out, pin_oe, pullup_en, r;
   logic [3:0] alu_flag_mask, alu_flags;
   logic [2:0] mem_bit;
   logic [1:0] bz_pin_sel;
   logic       mem_wr, alu_flag_we, wdt_timeout, clear_watchdog_instr_exec, halt_exec, wake_req;
   sfp_op_t    mem_op;
   int         fails = 0;
   int         checks_done = 0;
   int         cyc = 0;
   // ********
   // Pins, design and core
   // ********
   assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_val);
   sfp_regs i_dut (.clk_sys(clk_sys), .rst_n(rst_n), .mem_addr(mem_addr), .mem_wr(mem_wr),
      .mem_op(mem_op), .mem_bit(mem_bit), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
      .alu_flag_we(alu_flag_we), .alu_flag_mask(alu_flag_mask), .alu_flags(alu_flags),
      .wdt_timeout(wdt_timeout), .clear_watchdog_instr_exec(clear_watchdog_instr_exec), .halt_exec(halt_exec),
      .sleeping(sleeping), .wake_req(wake_req), .pin_in(pin_in), .pin_out(pin_out),
      .pin_oe(pin_oe), .pullup_en(pullup_en), .bz_wave(bz_wave), .bz_pin_sel(bz_pin_sel));
   sfp_core_model i_core (.clk_sys(clk_sys), .mem_rdata(mem_rdata), .mem_addr(mem_addr),
      .mem_wr(mem_wr), .mem_op(mem_op), .mem_bit(mem_bit), .mem_wdata(mem_wdata),
      .alu_flag_we(alu_flag_we), .alu_flag_mask(alu_flag_mask), .alu_flags(alu_flags),
      .wdt_timeout(wdt_timeout), .clear_watchdog_instr_exec(clear_watchdog_instr_exec), .halt_exec(halt_exec));
   initial begin
      forever #2 clk_sys = ~clk_sys;
   end
   // The whole run needs well under a thousand cycles.
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 3000) begin
         fails++;
         end_sim();
      end
   end
   task automatic end_sim();
      $display("checks_done %0d fails %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : end_sim
   // ********
   // Scenarios
   // ********
   task automatic t_reset();
      i_core.rd(ADDR_FLAG, r);
      `CHK(r[7:4], 4'h0)
      i_core.rd(ADDR_PORT_DIR, r);
      `CHK(r, RST_PORT_DIR)
      i_core.rd(ADDR_BUZZER, r);
      `CHK(r, 8'h00)
      `CHK({pin_oe, pullup_en, bz_pin_sel}, 18'h0)
   endtask : t_reset
   task automatic t_flags();
      i_core.wr(ADDR_FLAG, SFP_OP_WRITE, 3'h0, 8'hFF);
      i_core.rd(ADDR_FLAG, r);
      `CHK(r, 8'h0F)
      i_core.ev(3'h1);
      i_core.rd(ADDR_FLAG, r);
      `CHK(r, 8'h1F)
      i_core.ev(3'h4);
      i_core.rd(ADDR_FLAG, r);
      `CHK(r, 8'h3F)
      i_core.wr(ADDR_FLAG, SFP_OP_WRITE, 3'h0, 8'h00);
      i_core.rd(ADDR_FLAG, r);
      `CHK(r, 8'h30)
      i_core.ev(3'h2);
      i_core.rd(ADDR_FLAG, r);
      `CHK(r, 8'h00)
      i_core.ev(3'h4);
      i_core.ev(3'h1);
      i_core.wr(ADDR_FLAG, SFP_OP_SET, 3'h5, 8'h00);
      i_core.rd(ADDR_FLAG, r);
      `CHK(r, 8'h10)
   endtask : t_flags
   task automatic t_alu();
      i_core.alu(4'hF, 4'hA);
      i_core.rd(ADDR_FLAG, r);
      `CHK(r, 8'h1A)
      i_core.alu(4'h2, 4'h0);
      i_core.rd(ADDR_FLAG, r);
      `CHK(r, 8'h18)
      i_core.alu(4'h5, 4'h5);
      i_core.rd(ADDR_FLAG, r);
      `CHK(r, 8'h1D)
      // Software write and ALU update land on the same edge; the ALU owns carry.
      fork
         i_core.wr(ADDR_FLAG, SFP_OP_WRITE, 3'h0, 8'h0F);
         i_core.alu(4'h1, 4'h0);
      join
      i_core.rd(ADDR_FLAG, r);
      `CHK(r, 8'h1E)
      // A second power-up in mid-run must clear the power-down flag again.
      @(negedge clk_sys) rst_n = 1'b0;
      repeat (3) @(negedge clk_sys);
      rst_n = 1'b1;
      i_core.rd(ADDR_FLAG, r);
      `CHK(r[7:4], 4'h0)
   endtask : t_alu
   task automatic t_wake();
      logic seen;
      seen = 1'b0;
      i_core.wr(ADDR_WAKE, SFP_OP_WRITE, 3'h0, 8'h01);
      ext_val = 8'hFE;
      repeat (6) @(posedge clk_sys) seen |= (wake_req === 1'b1);
      `CHK(seen, 1'b0)
      @(negedge clk_sys) {sleeping, ext_val} = {1'b1, 8'hFD};
      repeat (6) @(posedge clk_sys) seen |= (wake_req === 1'b1);
      `CHK(seen, 1'b0)
      @(negedge clk_sys) ext_val = 8'hFC;
      repeat (8) @(posedge clk_sys) seen |= (wake_req === 1'b1);
      `CHK(seen, 1'b1)
      @(negedge clk_sys) {sleeping, ext_val} = {1'b0, 8'h5A};
   endtask : t_wake
   task automatic t_port();
      i_core.wr(ADDR_PORT_DATA, SFP_OP_WRITE, 3'h0, 8'h00);
      i_core.wr(ADDR_PORT_DIR, SFP_OP_CLR, 3'h3, 8'h00);
      `CHK({pin_oe, pin_out[3]}, 9'h10)
      i_core.rd(ADDR_PORT_DATA, r);
      `CHK(r, 8'h52)
      i_core.wr(ADDR_PORT_DATA, SFP_OP_SET, 3'h3, 8'h00);
      `CHK(pin_out[3], 1'b1)
      i_core.wr(ADDR_PULLUP, SFP_OP_WRITE, 3'h0, 8'hFF);
      `CHK(pullup_en, 8'hF7)
      i_core.wr(ADDR_PORT_DIR, SFP_OP_SET, 3'h3, 8'h00);
      `CHK({pin_oe, pullup_en}, 16'h00FF)
   endtask : t_port
   task automatic t_buzzer();
      logic [1:0] sel_exp [4] = '{2'h0, 2'h0, 2'h1, 2'h3};
      logic [1:0] pin_exp [4] = '{2'h2, 2'h2, 2'h3, 2'h1};
      i_core.wr(ADDR_PORT_DATA, SFP_OP_WRITE, 3'h0, 8'h02);
      i_core.wr(ADDR_PORT_DIR, SFP_OP_WRITE, 3'h0, 8'hFC);
      bz_wave = 1'b1;
      for (int c = 0; c < 4; c++) begin
         i_core.wr(ADDR_BUZZER, SFP_OP_WRITE, 3'h0, {4'hF, 2'(c), 2'h3});
         i_core.rd(ADDR_BUZZER, r);
         `CHK(r, {4'h0, 2'(c), 2'h0})
         `CHK(bz_pin_sel, sel_exp[c])
         `CHK({pin_oe[1:0], pin_out[1:0]}, {2'h3, pin_exp[c]})
      end
      @(negedge clk_sys) bz_wave = 1'b0;
      @(posedge clk_sys);
      `CHK(pin_out[1:0], 2'h2)
   endtask : t_buzzer
   initial begin
      repeat (3) @(posedge clk_sys);
      @(negedge clk_sys) rst_n = 1'b1;
      t_reset();
      t_flags();
      t_alu();
      t_wake();
      t_port();
      t_buzzer();
      end_sim();
   end
endmodule : tb_top
